// ---- dv/pamx_amp_model.sv ----
`timescale 1ns/1ps

module pamx_amp_model (
  input wire logic [15:0] gpio_out,
  input wire logic [15:0] gpio_oe,
  input wire logic [15:0] ext_drive,
  output logic [15:0] pad,
  output logic [7:0] amp_level,
  output logic rx_switch
);
  // undriven pins show the far side's level; the amplifier never drives back
  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      pad[i] = gpio_oe[i] ? gpio_out[i] : ext_drive[i];
    end
  end
  assign amp_level = pad[15:8];
  assign rx_switch = pad[6] & ~pad[7];
endmodule : pamx_amp_model

// ---- dv/testbench.sv ----
`timescale 1ns/1ps

module testbench;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic rx_on = 1'b0;
  logic frame_sync = 1'b0;
  logic [2:0] frame_sync_extra = 3'h0;
  logic conn_active = 1'b0;
  logic [2:0] conn_id = 3'h0;
  // far side shows the inverse of the ordinary output value on every pin
  logic [15:0] ext_drive = 16'ha5c3;
  logic [15:0] pad;
  logic [15:0] gpio_out;
  logic [15:0] gpio_oe;
  logic frame_sync_pin;
  logic [7:0] amp_level;
  logic rx_switch;
  logic [31:0] q;
  int failures = 0;
  int compares = 0;

  always #20 mclk = ~mclk;

  pamx_top pamx_top_inst (.mclk(mclk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_on(rx_on), .frame_sync(frame_sync),
    .frame_sync_extra(frame_sync_extra), .conn_active(conn_active), .conn_id(conn_id),
    .gpio_in(pad), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .frame_sync_pin(frame_sync_pin));

  pamx_amp_model pamx_amp_model_inst (.gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .ext_drive(ext_drive), .pad(pad), .amp_level(amp_level), .rx_switch(rx_switch));

  task automatic give_verdict();
    if (failures == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask : tick

  // request held until waitrequest is sampled low at an edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus

  task automatic t_reset();
    bus(1'b0, 8'h00, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    chk({16'h0000, gpio_oe}, 32'h0000_0000);
  endtask : t_reset

  task automatic t_gpio();
    bus(1'b1, 8'h08, 32'h0000_5a3c);
    bus(1'b1, 8'h0C, 32'h0000_00ff);
    tick(3);
    chk({gpio_oe, gpio_out}, 32'h00ff_5a3c);
    bus(1'b0, 8'h10, 32'h0000_0000);
    chk(q, 32'h0000_a53c);
  endtask : t_gpio

  task automatic t_rx();
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, 8'h00, (i < 2) ? 32'h0000_0001 : 32'h0000_0002);
      @(posedge mclk);
      rx_on <= i[0];
      tick(3);
      // other enable bit stays ordinary: gpio_out bits 7:6 of 0x3c are 0
      if (i < 2)
      begin
        chk(32'({gpio_oe[7:6], gpio_out[7:6]}), {28'h0, 2'b11, 1'b0, i[0]});
        chk(32'(rx_switch), 32'(i[0]));
      end
      else
        chk(32'({gpio_oe[7:6], gpio_out[7:6]}), {28'h0, 2'b11, !i[0], 1'b0});
    end
  endtask : t_rx

  task automatic t_level();
    bus(1'b1, 8'h2C, 32'h0000_00a5);
    bus(1'b1, 8'h3C, 32'h0000_005a);
    bus(1'b1, 8'h00, 32'h0000_03fc);
    @(posedge mclk);
    conn_active <= 1'b1;
    conn_id <= 3'h3;
    tick(4);
    chk(32'({gpio_oe[15:8], amp_level}), 32'h0000_ffa5);
    conn_id <= 3'h7;
    tick(4);
    chk(32'(amp_level), 32'h0000_005a);
    conn_active <= 1'b0;
    tick(4);
    chk(32'(amp_level), 32'h0000_0000);
    conn_active <= 1'b1;
    conn_id <= 3'h3;
    bus(1'b1, 8'h00, 32'h0000_0020);
    tick(4);
    // only gpio11 switched; the others keep ordinary value 0x5a and enable 0
    chk(32'({gpio_oe[15:8], gpio_out[15:8]}), 32'h0000_0852);
  endtask : t_level

  task automatic t_sync();
    bus(1'b1, 8'h00, 32'h0000_03fc);
    bus(1'b1, 8'h04, 32'h0000_0007);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      frame_sync_extra <= i[2:0];
      frame_sync <= i[0];
      tick(3);
      chk(32'(gpio_out[15:8]), {24'h0, 5'h14, i[2:0]});
      chk(32'(frame_sync_pin), 32'(i[0]));
    end
    bus(1'b1, 8'h04, 32'h0000_0002);
    @(posedge mclk);
    frame_sync_extra <= 3'b010;
    tick(3);
    chk(32'(gpio_out[15:8]), 32'h0000_00a7);
  endtask : t_sync

  task automatic t_regs();
    bus(1'b0, 8'h18, 32'h0000_0000);
    chk(q, 32'h0001_03a5);
    bus(1'b0, 8'h3C, 32'h0000_0000);
    chk(q, 32'h0000_005a);
    bus(1'b0, 8'h14, 32'h0000_0000);
    chk(q, 32'h0000_a73c);
    bus(1'b0, 8'h2D, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    avs_byteenable <= 4'he;
    bus(1'b1, 8'h20, 32'h0000_00ff);
    avs_byteenable <= 4'h2;
    bus(1'b1, 8'h00, 32'h0000_0100);
    avs_byteenable <= 4'hf;
    bus(1'b0, 8'h20, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1'b0, 8'h00, 32'h0000_0000);
    chk(q, 32'h0000_01fc);
    bus(1'b1, 8'h04, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'h0000_0008);
    conn_id <= 3'h7;
    tick(4);
    // gpio9 carries level line one, gpio8 keeps its ordinary value and enable
    chk(32'({gpio_oe[9:8], gpio_out[9:8]}), 32'h0000_000a);
  endtask : t_regs

  task automatic t_map();
    bus(1'b1, 8'h40, 32'hffff_ffff);
    bus(1'b0, 8'h40, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    bus(1'b1, 8'h00, 32'hffff_ffff);
    bus(1'b0, 8'h00, 32'h0000_0000);
    chk(q, 32'h0000_03ff);
    tick(3);
    chk({16'h0000, gpio_oe}, 32'h0000_ffff);
    @(posedge mclk);
    reset <= 1'b1;
    tick(2);
    reset <= 1'b0;
    tick(2);
    chk({16'h0000, gpio_oe}, 32'h0000_0000);
    bus(1'b0, 8'h00, 32'h0000_0000);
    chk(q, 32'h0000_0000);
  endtask : t_map

  initial
  begin
    tick(20);
    reset <= 1'b0;
    t_reset();
    t_gpio();
    t_rx();
    t_level();
    t_sync();
    t_regs();
    t_map();
    give_verdict();
  end

  // whole run needs well under 2000 cycles
  initial
  begin
    #(40 * 20000);
    failures++;
    give_verdict();
  end
endmodule : testbench

// ---- verilog/pamx_defs.svh ----
`ifndef PAMX_DEFS_SVH
`define PAMX_DEFS_SVH

// byte offsets on the register port
`define PAMX_OFS_ALT_EN 8'h00
`define PAMX_OFS_SYNC_SEL 8'h04
`define PAMX_OFS_GPIO_OUT 8'h08
`define PAMX_OFS_GPIO_OE 8'h0C
`define PAMX_OFS_GPIO_IN 8'h10
`define PAMX_OFS_PIN_STATE 8'h14
`define PAMX_OFS_CONN_STATE 8'h18
`define PAMX_OFS_LEVEL_BASE 8'h20
`define PAMX_OFS_LEVEL_LAST 8'h3C

// reset values
`define PAMX_RST_ALT_EN 10'h000
`define PAMX_RST_SYNC_SEL 3'h0
`define PAMX_RST_GPIO_OUT 16'h0000
`define PAMX_RST_GPIO_OE 16'h0000
`define PAMX_RST_LEVEL 8'h00

// enable register fields
`define PAMX_ALT_RXON_BIT 0
`define PAMX_ALT_NRXON_BIT 1
`define PAMX_ALT_LVL_LSB 2
`define PAMX_ALT_WIDTH 10

// pin positions
`define PAMX_PIN_RXON 6
`define PAMX_PIN_NRXON 7
`define PAMX_PIN_LVL_LSB 8
`define PAMX_PIN_COUNT 16

// connection state fields
`define PAMX_CONN_ID_LSB 8
`define PAMX_CONN_ACTIVE_BIT 16

// sizes
`define PAMX_LEVEL_BITS 8
`define PAMX_SYNC_EXTRA 3
`define PAMX_CONN_COUNT 8

`endif

// ---- verilog/pamx_if.sv ----
`timescale 1ns/1ps

interface pamx_if;
  logic wr_en;
  logic [2:0] wr_idx;
  pamx_pkg::pamx_level_t wr_data;
  logic [2:0] rd_idx;
  pamx_pkg::pamx_level_t rd_data;
  logic conn_active;
  logic [2:0] conn_id;
  pamx_pkg::pamx_level_t level;

  modport ctl (
    output wr_en,
    output wr_idx,
    output wr_data,
    output rd_idx,
    output conn_active,
    output conn_id,
    input rd_data,
    input level
  );

  modport tbl (
    input wr_en,
    input wr_idx,
    input wr_data,
    input rd_idx,
    input conn_active,
    input conn_id,
    output rd_data,
    output level
  );
endinterface : pamx_if

// ---- verilog/pamx_level.sv ----
`timescale 1ns/1ps
`include "pamx_defs.svh"

module pamx_level (
  input wire logic mclk,
  input wire logic reset,
  pamx_if.tbl bus
);

  pamx_pkg::pamx_level_t table_q [`PAMX_CONN_COUNT];
  pamx_pkg::pamx_level_t next_table [`PAMX_CONN_COUNT];
  pamx_pkg::pamx_level_t level_q;
  pamx_pkg::pamx_level_t next_level;

  always_comb
  begin
    for (int i = 0; i < `PAMX_CONN_COUNT; i++)
    begin
      next_table[i] = table_q[i];
    end
    if (bus.wr_en)
    begin
      next_table[bus.wr_idx] = bus.wr_data;
    end
    // idle radio keeps the amplifier at its lowest setting
    next_level = bus.conn_active ? table_q[bus.conn_id] : `PAMX_RST_LEVEL; // RULE6
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      for (int i = 0; i < `PAMX_CONN_COUNT; i++)
      begin
        table_q[i] <= `PAMX_RST_LEVEL;
      end
      level_q <= `PAMX_RST_LEVEL;
    end
    else
    begin
      table_q <= next_table;
      level_q <= next_level;
    end
  end

  assign bus.rd_data = table_q[bus.rd_idx];
  assign bus.level = level_q;

  a_level_pick: assert property (@(posedge mclk) disable iff (reset) // RULE6
    bus.conn_active |=> level_q == $past(table_q[bus.conn_id]))
    else $error("level lines do not follow the active connection");

  a_level_idle: assert property (@(posedge mclk) disable iff (reset) // RULE6
    !bus.conn_active |=> level_q == `PAMX_RST_LEVEL)
    else $error("level lines not cleared without a connection");

endmodule : pamx_level

// ---- verilog/pamx_pkg.sv ----
`include "pamx_defs.svh"

package pamx_pkg;

  typedef enum logic [1:0] {
    pamx_st_idle = 2'b01,
    pamx_st_ack = 2'b10
  } pamx_bus_e;

  typedef logic [`PAMX_LEVEL_BITS-1:0] pamx_level_t;

  function automatic logic [31:0] pamx_be_merge(input logic [31:0] old_val,
                                                input logic [31:0] new_val,
                                                input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
      begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction : pamx_be_merge

  function automatic logic pamx_is_level(input logic [7:0] addr);
    // unaligned offsets stay unmapped, like every other register
    return (addr >= `PAMX_OFS_LEVEL_BASE) && (addr <= `PAMX_OFS_LEVEL_LAST)
           && (addr[1:0] == 2'b00);
  endfunction : pamx_is_level

endpackage : pamx_pkg

// ---- verilog/pamx_top.sv ----
// Summary of operation
// [RULE1] A software register selects the amplifier alternate functions on gpio6 to gpio15.
// [RULE2] Each enable bit moves one amplifier signal onto its own pin, independent of the rest.
// [RULE3] When enabled gpio6 copies the receive-on output and gpio7 carries its inverse.
// [RULE4] When enabled gpio8 to gpio15 carry amplifier level lines zero to seven in order.
// [RULE5] Pins gpio8 to gpio10 may instead carry the three extra voice frame syncs.
// [RULE6] The level lines follow the power level programmed for the active connection.
// [RULE7] The three extra frame syncs supplement the single dedicated frame sync pin.
// [RULE8] A clear enable bit leaves the pin as ordinary gpio, and reset clears all enables.
`timescale 1ns/1ps
`include "pamx_defs.svh"

module pamx_top (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic rx_on,
  input wire logic frame_sync,
  input wire logic [`PAMX_SYNC_EXTRA-1:0] frame_sync_extra,
  input wire logic conn_active,
  input wire logic [2:0] conn_id,
  input wire logic [`PAMX_PIN_COUNT-1:0] gpio_in,
  output logic [`PAMX_PIN_COUNT-1:0] gpio_out,
  output logic [`PAMX_PIN_COUNT-1:0] gpio_oe,
  output logic frame_sync_pin
);

  pamx_if lvl_if ();

  pamx_pkg::pamx_bus_e state;
  pamx_pkg::pamx_bus_e next_state;
  logic [31:0] readdata_q;
  logic [31:0] next_readdata;

  logic [`PAMX_ALT_WIDTH-1:0] alt_en;
  logic [`PAMX_ALT_WIDTH-1:0] next_alt_en;
  logic [`PAMX_SYNC_EXTRA-1:0] sync_sel;
  logic [`PAMX_SYNC_EXTRA-1:0] next_sync_sel;
  logic [`PAMX_PIN_COUNT-1:0] out_reg;
  logic [`PAMX_PIN_COUNT-1:0] next_out_reg;
  logic [`PAMX_PIN_COUNT-1:0] oe_reg;
  logic [`PAMX_PIN_COUNT-1:0] next_oe_reg;

  logic [`PAMX_PIN_COUNT-1:0] gpio_meta;
  logic [`PAMX_PIN_COUNT-1:0] gpio_sync;
  logic [`PAMX_PIN_COUNT-1:0] pin_out_q;
  logic [`PAMX_PIN_COUNT-1:0] pin_oe_q;
  logic [`PAMX_PIN_COUNT-1:0] next_pin_out;
  logic [`PAMX_PIN_COUNT-1:0] next_pin_oe;
  logic [`PAMX_PIN_COUNT-1:0] alt_val;
  logic sync_pin_q;

  logic wr_take;
  logic [31:0] merged;

  pamx_level u_level (
    .mclk(mclk),
    .reset(reset),
    .bus(lvl_if.tbl)
  );

  // bus slave: one wait cycle, then a single acknowledge cycle
  always_comb
  begin
    next_state = state;
    next_readdata = readdata_q;
    case (state)
      pamx_pkg::pamx_st_idle:
      begin
        if (avs_read || avs_write)
        begin
          next_state = pamx_pkg::pamx_st_ack;
        end
        if (avs_read)
        begin
          next_readdata = 32'h0000_0000;
          if (pamx_pkg::pamx_is_level(avs_address))
          begin
            next_readdata[`PAMX_LEVEL_BITS-1:0] = lvl_if.rd_data;
          end
          else
          begin
            case (avs_address)
              `PAMX_OFS_ALT_EN: next_readdata[`PAMX_ALT_WIDTH-1:0] = alt_en;
              `PAMX_OFS_SYNC_SEL: next_readdata[`PAMX_SYNC_EXTRA-1:0] = sync_sel;
              `PAMX_OFS_GPIO_OUT: next_readdata[`PAMX_PIN_COUNT-1:0] = out_reg;
              `PAMX_OFS_GPIO_OE: next_readdata[`PAMX_PIN_COUNT-1:0] = oe_reg;
              `PAMX_OFS_GPIO_IN: next_readdata[`PAMX_PIN_COUNT-1:0] = gpio_sync;
              `PAMX_OFS_PIN_STATE: next_readdata[`PAMX_PIN_COUNT-1:0] = pin_out_q;
              `PAMX_OFS_CONN_STATE:
              begin
                next_readdata[`PAMX_LEVEL_BITS-1:0] = lvl_if.level;
                next_readdata[`PAMX_CONN_ID_LSB +: 3] = conn_id;
                next_readdata[`PAMX_CONN_ACTIVE_BIT] = conn_active;
              end
              default: next_readdata = 32'h0000_0000;
            endcase
          end
        end
      end
      pamx_pkg::pamx_st_ack:
      begin
        next_state = pamx_pkg::pamx_st_idle;
      end
      default:
      begin
        next_state = pamx_pkg::pamx_st_idle;
      end
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state <= pamx_pkg::pamx_st_idle;
      readdata_q <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      readdata_q <= next_readdata;
    end
  end

  assign avs_waitrequest = (state != pamx_pkg::pamx_st_ack);
  assign avs_readdata = readdata_q;
  assign wr_take = (state == pamx_pkg::pamx_st_ack) && avs_write;

  // software registers, written at the acknowledge edge only
  always_comb
  begin
    next_alt_en = alt_en;
    next_sync_sel = sync_sel;
    next_out_reg = out_reg;
    next_oe_reg = oe_reg;
    merged = 32'h0000_0000;
    if (wr_take)
    begin
      case (avs_address)
        `PAMX_OFS_ALT_EN:
        begin
          merged = pamx_pkg::pamx_be_merge({22'h00_0000, alt_en}, avs_writedata,
                                           avs_byteenable);
          next_alt_en = merged[`PAMX_ALT_WIDTH-1:0]; // RULE1
        end
        `PAMX_OFS_SYNC_SEL:
        begin
          merged = pamx_pkg::pamx_be_merge({29'h0000_0000, sync_sel}, avs_writedata,
                                           avs_byteenable);
          next_sync_sel = merged[`PAMX_SYNC_EXTRA-1:0]; // RULE5
        end
        `PAMX_OFS_GPIO_OUT:
        begin
          merged = pamx_pkg::pamx_be_merge({16'h0000, out_reg}, avs_writedata,
                                           avs_byteenable);
          next_out_reg = merged[`PAMX_PIN_COUNT-1:0];
        end
        `PAMX_OFS_GPIO_OE:
        begin
          merged = pamx_pkg::pamx_be_merge({16'h0000, oe_reg}, avs_writedata,
                                           avs_byteenable);
          next_oe_reg = merged[`PAMX_PIN_COUNT-1:0];
        end
        default: merged = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      alt_en <= `PAMX_RST_ALT_EN; // RULE8
      sync_sel <= `PAMX_RST_SYNC_SEL;
      out_reg <= `PAMX_RST_GPIO_OUT;
      oe_reg <= `PAMX_RST_GPIO_OE;
    end
    else
    begin
      alt_en <= next_alt_en;
      sync_sel <= next_sync_sel;
      out_reg <= next_out_reg;
      oe_reg <= next_oe_reg;
    end
  end

  // level table access, low byte lane only
  assign lvl_if.wr_en = wr_take && pamx_pkg::pamx_is_level(avs_address) && avs_byteenable[0];
  assign lvl_if.wr_idx = avs_address[4:2];
  assign lvl_if.wr_data = avs_writedata[`PAMX_LEVEL_BITS-1:0];
  assign lvl_if.rd_idx = avs_address[4:2];
  assign lvl_if.conn_active = conn_active;
  assign lvl_if.conn_id = conn_id;

  // alternate values; the lower pins have no amplifier function here
  always_comb
  begin
    alt_val = out_reg;
    alt_val[`PAMX_PIN_RXON] = rx_on; // RULE3
    alt_val[`PAMX_PIN_NRXON] = ~rx_on; // RULE3
    for (int k = 0; k < `PAMX_LEVEL_BITS; k++)
    begin
      alt_val[`PAMX_PIN_LVL_LSB + k] = lvl_if.level[k]; // RULE4
    end
    for (int k = 0; k < `PAMX_SYNC_EXTRA; k++)
    begin
      if (sync_sel[k])
      begin
        alt_val[`PAMX_PIN_LVL_LSB + k] = frame_sync_extra[k]; // RULE5
      end
    end
  end

  // pin mux, one enable bit per pin for gpio6 to gpio15
  always_comb
  begin
    next_pin_out = out_reg; // RULE8
    next_pin_oe = oe_reg;
    for (int i = 0; i < `PAMX_ALT_WIDTH; i++)
    begin
      if (alt_en[i])
      begin
        next_pin_out[`PAMX_PIN_RXON + i] = alt_val[`PAMX_PIN_RXON + i]; // RULE2
        next_pin_oe[`PAMX_PIN_RXON + i] = 1'b1;
      end
    end
  end

  // dedicated sync goes through one flop too, so all four syncs stay aligned
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pin_out_q <= `PAMX_RST_GPIO_OUT;
      pin_oe_q <= `PAMX_RST_GPIO_OE;
      sync_pin_q <= 1'b0;
      gpio_meta <= 16'h0000;
      gpio_sync <= 16'h0000;
    end
    else
    begin
      pin_out_q <= next_pin_out;
      pin_oe_q <= next_pin_oe;
      sync_pin_q <= frame_sync; // RULE7
      gpio_meta <= gpio_in;
      gpio_sync <= gpio_meta;
    end
  end

  assign gpio_out = pin_out_q;
  assign gpio_oe = pin_oe_q;
  assign frame_sync_pin = sync_pin_q;

  a_alt_write: assert property (@(posedge mclk) disable iff (reset) // RULE1
    (wr_take && avs_address == `PAMX_OFS_ALT_EN && avs_byteenable[1:0] == 2'b11)
    |=> alt_en == $past(avs_writedata[`PAMX_ALT_WIDTH-1:0]))
    else $error("enable register did not take the written value");

  a_alt_hold: assert property (@(posedge mclk) disable iff (reset) // RULE1
    !(wr_take && avs_address == `PAMX_OFS_ALT_EN) |=> $stable(alt_en))
    else $error("enable register changed without a write");

  a_bit_indep: assert property (@(posedge mclk) disable iff (reset) // RULE2
    (alt_en[3] && !alt_en[2] && !sync_sel[1])
    |=> gpio_out[9] == $past(lvl_if.level[1]) && gpio_out[8] == $past(out_reg[8]))
    else $error("enable bits are not independent");

  a_rxon_copy: assert property (@(posedge mclk) disable iff (reset) // RULE3
    alt_en[`PAMX_ALT_RXON_BIT] |=> gpio_out[6] == $past(rx_on) && gpio_oe[6])
    else $error("gpio6 does not copy receive-on");

  a_nrxon_inv: assert property (@(posedge mclk) disable iff (reset) // RULE3
    alt_en[`PAMX_ALT_NRXON_BIT] |=> gpio_out[7] == !$past(rx_on) && gpio_oe[7])
    else $error("gpio7 is not the inverse of receive-on");

  a_level_top: assert property (@(posedge mclk) disable iff (reset) // RULE4
    alt_en[9] |=> gpio_out[15] == $past(lvl_if.level[7]) && gpio_oe[15])
    else $error("level line seven not on gpio15");

  a_level_low: assert property (@(posedge mclk) disable iff (reset) // RULE4
    (alt_en[2] && !sync_sel[0]) |=> gpio_out[8] == $past(lvl_if.level[0]))
    else $error("level line zero not on gpio8");

  a_sync_share: assert property (@(posedge mclk) disable iff (reset) // RULE5
    (alt_en[4] && sync_sel[2]) |=> gpio_out[10] == $past(frame_sync_extra[2]))
    else $error("third extra sync not on gpio10");

  a_sync_align: assert property (@(posedge mclk) disable iff (reset) // RULE7
    (alt_en[2] && sync_sel[0] && frame_sync == frame_sync_extra[0])
    |=> frame_sync_pin == gpio_out[8])
    else $error("extra sync not aligned with dedicated sync");

  a_gpio_plain: assert property (@(posedge mclk) disable iff (reset) // RULE8
    !alt_en[5] |=> gpio_out[11] == $past(out_reg[11]) && gpio_oe[11] == $past(oe_reg[11]))
    else $error("disabled pin lost its ordinary function");

  a_reset_clear: assert property (@(posedge mclk) // RULE8
    reset |=> alt_en == `PAMX_RST_ALT_EN && gpio_oe == `PAMX_RST_GPIO_OE)
    else $error("reset did not clear the enables");

  a_bus_answer: assert property (@(posedge mclk) disable iff (reset)
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus request not answered in one cycle");

endmodule : pamx_top
